// file: src/dct_pkg.sv
// Purpose: shared constants and types for the command-timing link
// Assumes: one nCK is one period of the link clock made by the controller end
// Notes: times kept in ps, converted to nCK with rounding up
package dct_pkg;
  // Link shape
  localparam int BANKS = 8;
  localparam int BEATS = 4;           // Burst length 8 over two edges per nCK, one beat per nCK
  localparam int SYS_PERIOD_PS = 8000; // clk_sys at 125 MHz
  // Fixed spacings in nCK
  localparam int CCD_NCK = 4;
  localparam int MRD_NCK = 4;
  localparam int MPRR_NCK = 1;
  localparam int RTP_MIN_NCK = 4;
  localparam int WTR_MIN_NCK = 4;
  // Spacings in ps
  localparam int RTP_PS = 7500;
  localparam int WTR_PS = 7500;
  // Strobe framing in nCK slots (whole slots cover the 0.9 and 0.3 minimums)
  localparam int PRE_NCK = 1;
  localparam int POST_NCK = 1;

  // Command codes on the link
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD = 4'h2,
    CMD_WR = 4'h3,
    CMD_WRA = 4'h4,
    CMD_PRE = 4'h5,
    CMD_MRS = 4'h6,
    CMD_REF = 4'h7,
    CMD_MPRX = 4'h8
  } dct_cmd_t;

  // Round a time up to whole link clocks, never below one
  function automatic int dctToNck(input int ps, input int tckPs);
    int n;
    n = (ps + tckPs - 1) / tckPs;
    return (n < 1) ? 1 : n;
  endfunction

  // Larger of a clock floor and a rounded-up time
  function automatic int dctMaxNck(input int nck, input int ps, input int tckPs);
    int t;
    t = dctToNck(ps, tckPs);
    return (t > nck) ? t : nck;
  endfunction
endpackage

// file: src/dct_link_if.sv
// Purpose: link between the controller end and the memory end
// Assumes: undriven strobe and data read as zero
// Notes: the two-way pins are resolved here from the active-low enables
`timescale 1ns/100ps
interface dct_link_if;
  import dct_pkg::*;
  logic ck;            // Link clock from the controller
  dct_cmd_t cmd;       // Command, changes on ck falling
  logic [2:0] bank;    // Bank address
  logic [7:0] dqCtl;   // Data driven by controller
  logic dqCtlOe_n;     // Controller data enable, low drives
  logic dqsCtl;        // Strobe driven by controller
  logic dqsCtlOe_n;    // Controller strobe enable, low drives
  logic [7:0] dqMem;   // Data driven by memory
  logic dqMemOe_n;     // Memory data enable, low drives
  logic dqsMem;        // Strobe driven by memory
  logic dqsMemOe_n;    // Memory strobe enable, low drives
  logic [7:0] dq;      // Resolved data wire
  logic dqs;           // Resolved strobe wire

  // Wire level from enables, idle low
  assign dq = !dqCtlOe_n ? dqCtl : (!dqMemOe_n ? dqMem : 8'h00);
  assign dqs = !dqsCtlOe_n ? dqsCtl : (!dqsMemOe_n ? dqsMem : 1'b0);

  modport ctl (output ck, output cmd, output bank, output dqCtl, output dqCtlOe_n,
    output dqsCtl, output dqsCtlOe_n, input dq, input dqs);
  modport mem (input ck, input cmd, input bank, output dqMem, output dqMemOe_n,
    output dqsMem, output dqsMemOe_n, input dq, input dqs);
endinterface

// file: src/dct_mem_end.sv
// Purpose: memory end, decodes commands and frames the read strobe
// Assumes: link inputs are asynchronous, two flip-flops before use
// Notes: one 32-bit word per bank, written and read as four beats
`timescale 1ns/100ps
module dct_mem_end import dct_pkg::*; #(
  parameter int RL = 6 // Read latency in nCK, at least 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  dct_link_if.mem link,
  output logic cmdSeen,
  output dct_cmd_t cmdLast
);
  // Burst states
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_RD = 3'b010,
    M_WR = 3'b100
  } dct_mstate_t;

  typedef struct packed {
    logic [2:0] ckSync;      // Stage 1, stage 2, previous
    logic [3:0] cmd1;        // First sync stage of command
    logic [3:0] cmd2;
    logic [2:0] bank1;
    logic [2:0] bank2;
    logic [2:0] dqsSync;     // Stage 1, stage 2, previous
    logic [7:0] dq1;
    logic [7:0] dq2;
    dct_mstate_t st;
    logic [7:0] slot;        // nCK since read command
    logic [1:0] beat;        // Write beat index
    logic [2:0] bankSel;
    logic [BANKS-1:0][31:0] store; // Data held per bank
    logic [7:0] dqOut;
    logic dqsOut;
    logic oe_n;              // Shared strobe and data enable
    logic seen;
    logic [3:0] last;
  } dct_mem_state_t;

  dct_mem_state_t s_reg, s_next;
  logic ckRise;
  logic dqsEdge;

  // Edges found after the second stage only
  assign ckRise = s_reg.ckSync[1] & ~s_reg.ckSync[2];
  assign dqsEdge = s_reg.dqsSync[1] ^ s_reg.dqsSync[2];

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.ckSync = {s_reg.ckSync[1], s_reg.ckSync[0], link.ck};
    s_next.cmd1 = link.cmd;
    s_next.cmd2 = s_reg.cmd1;
    s_next.bank1 = link.bank;
    s_next.bank2 = s_reg.bank1;
    s_next.dqsSync = {s_reg.dqsSync[1], s_reg.dqsSync[0], link.dqs};
    s_next.dq1 = link.dq;
    s_next.dq2 = s_reg.dq1;
    s_next.seen = 1'b0;
    // Commands sampled on ck rising in every state, so a precharge in a burst is kept
    if (ckRise && s_reg.cmd2 != CMD_NOP) begin
      s_next.seen = 1'b1;
      s_next.last = s_reg.cmd2;
    end
    unique case (s_reg.st)
      M_IDLE: begin
        // Bursts start only from idle; the bank is held for the whole burst
        if (ckRise && s_reg.cmd2 == CMD_RD) begin
          s_next.bankSel = s_reg.bank2;
          s_next.slot = 8'h00;
          s_next.st = M_RD;
        end else if (ckRise && (s_reg.cmd2 == CMD_WR || s_reg.cmd2 == CMD_WRA)) begin
          s_next.bankSel = s_reg.bank2;
          s_next.beat = 2'b00;
          s_next.st = M_WR;
        end
      end
      M_RD: begin
        // Strobe framing counted in link rising edges
        if (ckRise) begin
          s_next.slot = s_reg.slot + 8'h01;
          if (s_next.slot == 8'(RL - PRE_NCK)) begin
            s_next.oe_n = 1'b0; // RL15
            s_next.dqsOut = 1'b0; // RL13
          end else if (s_next.slot >= 8'(RL) && s_next.slot < 8'(RL + BEATS)) begin
            s_next.dqsOut = ~s_next.slot[0] ^ RL[0];
            s_next.dqOut = s_reg.store[s_reg.bankSel][8 * (s_next.slot - 8'(RL)) +: 8];
            if (s_next.slot == 8'(RL + BEATS - 1)) begin
              s_next.dqsOut = 1'b0; // RL14
            end
          end else if (s_next.slot == 8'(RL + BEATS)) begin
            s_next.oe_n = 1'b1; // RL16
            s_next.st = M_IDLE;
          end
        end
      end
      M_WR: begin
        // Each strobe edge carries one beat
        if (dqsEdge) begin
          s_next.store[s_reg.bankSel][8 * s_reg.beat +: 8] = s_reg.dq2;
          s_next.beat = s_reg.beat + 2'b01;
          if (s_reg.beat == 2'(BEATS - 1)) begin
            s_next.st = M_IDLE;
          end
        end
      end
      default: begin
        s_next.st = M_IDLE;
      end
    endcase
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= M_IDLE;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dqMem = s_reg.dqOut;
  assign link.dqsMem = s_reg.dqsOut;
  assign link.dqMemOe_n = s_reg.oe_n;
  assign link.dqsMemOe_n = s_reg.oe_n;
  assign cmdSeen = s_reg.seen;
  assign cmdLast = dct_cmd_t'(s_reg.last);
endmodule // dct_mem_end

// file: src/dct_ctrl_end.sv
// Purpose: controller end, makes the link clock and gates commands by spacing
// Assumes: user holds a request until reqReady; one burst in flight
// Notes: counters load N-1 at issue, so the next legal slot is N nCK later
// Summary of operation
// RL1 - Column commands at least four clocks apart
// RL2 - Mode register sets four clocks apart
// RL3 - After mode set wait update delay
// RL4 - One clock after leaving register readout
// RL5 - Read to precharge: max(4, 7.5ns)
// RL6 - Write data end to read: max(4, 7.5ns)
// RL7 - Auto-precharge write busy: recovery plus precharge
// RL8 - Activate to column waits activate delay
// RL9 - Activate to activate/refresh: row cycle
// RL10 - Row open at least minimum active period
// RL11 - Write strobe preamble at least 0.9 clock
// RL12 - Write strobe postamble at least 0.3 clock
// RL13 - Memory read preamble at least 0.9 clock
// RL14 - Memory read postamble at least 0.3 clock
// RL15 - Memory drives strobe from read latency minus one
// RL16 - Memory releases strobe at latency plus half burst
// RL17 - Round times up; down-counters gate issue
`timescale 1ns/100ps
module dct_ctrl_end import dct_pkg::*; #(
  parameter int DIV = 10,        // clk_sys cycles per link clock, even
  parameter int CWL = 5,         // Write latency in nCK, at least 2
  parameter int RL = 6,          // Read latency in nCK
  parameter int T_RCD_PS = 15000,
  parameter int T_RP_PS = 15000,
  parameter int T_RAS_PS = 36000,
  parameter int T_RC_PS = 51000,
  parameter int T_MOD_PS = 15000,
  parameter int MOD_MIN_NCK = 12,
  parameter int WR_NCK = 8       // Programmed write recovery
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reqValid,
  input wire dct_cmd_t reqCmd,
  input wire logic [2:0] reqBank,
  input wire logic [31:0] reqWdata,
  output logic reqReady,
  output logic rdValid,
  output logic [31:0] rdData,
  dct_link_if.ctl link
);
  // Derived counts, rounded up
  localparam int TCK_PS = SYS_PERIOD_PS * DIV;
  localparam int HALF = DIV / 2;
  localparam int RCD_N = dctToNck(T_RCD_PS, TCK_PS); // RL17
  localparam int RP_N = dctToNck(T_RP_PS, TCK_PS);
  localparam int RAS_N = dctToNck(T_RAS_PS, TCK_PS);
  localparam int RC_N = dctToNck(T_RC_PS, TCK_PS);
  localparam int MOD_N = dctMaxNck(MOD_MIN_NCK, T_MOD_PS, TCK_PS);
  localparam int RTP_N = dctMaxNck(RTP_MIN_NCK, RTP_PS, TCK_PS);
  localparam int WTR_N = dctMaxNck(WTR_MIN_NCK, WTR_PS, TCK_PS);
  localparam int WEND_N = CWL + BEATS; // Slot after last write beat

  // Burst states
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_WR = 3'b010,
    C_RD = 3'b100
  } dct_cstate_t;

  typedef struct packed {
    logic [7:0] divCnt;
    logic ck;
    logic [3:0] cmd;
    logic [2:0] bank;
    logic [7:0] ccd;
    logic [7:0] mrd;
    logic [7:0] modw;
    logic [7:0] mprr;
    logic [7:0] wtr;
    logic [BANKS-1:0][7:0] rcd;
    logic [BANKS-1:0][7:0] rc;
    logic [BANKS-1:0][7:0] ras;
    logic [BANKS-1:0][7:0] rtp;
    logic [BANKS-1:0][7:0] rp;
    logic [BANKS-1:0][7:0] dal;
    logic [BANKS-1:0] open;
    dct_cstate_t st;
    logic [7:0] slot;        // nCK since column command
    logic [31:0] wdata;
    logic [31:0] rdat;
    logic [1:0] beat;
    logic [2:0] dqsSync;     // Stage 1, stage 2, previous
    logic [7:0] dq1;
    logic [7:0] dq2;
    logic [7:0] dqOut;
    logic dqsOut;
    logic oe_n;
    logic rdv;
  } dct_ctl_state_t;

  dct_ctl_state_t s_reg, s_next;
  logic fallEn;
  logic legal;
  logic allIdle;
  logic dqsEdge;

  // Falling edge of ck is the issue slot
  assign fallEn = s_reg.divCnt == 8'(HALF - 1);
  assign dqsEdge = s_reg.dqsSync[1] ^ s_reg.dqsSync[2];

  // Legality of the pending request
  always_comb begin
    allIdle = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (s_reg.open[b] || s_reg.rc[b] != 8'h00 || s_reg.rp[b] != 8'h00 ||
          s_reg.dal[b] != 8'h00) begin
        allIdle = 1'b0;
      end
    end
    legal = 1'b0;
    unique case (reqCmd)
      CMD_ACT: legal = !s_reg.open[reqBank] && s_reg.rc[reqBank] == 8'h00 && // RL9
        s_reg.rp[reqBank] == 8'h00 && s_reg.dal[reqBank] == 8'h00; // RL7
      CMD_RD: legal = s_reg.open[reqBank] && s_reg.rcd[reqBank] == 8'h00 && // RL8
        s_reg.ccd == 8'h00 && s_reg.wtr == 8'h00 && s_reg.st == C_IDLE; // RL1 RL6
      CMD_WR, CMD_WRA: legal = s_reg.open[reqBank] && s_reg.rcd[reqBank] == 8'h00 &&
        s_reg.ccd == 8'h00 && s_reg.st == C_IDLE; // RL1
      CMD_PRE: legal = s_reg.open[reqBank] && s_reg.ras[reqBank] == 8'h00 && // RL10
        s_reg.rtp[reqBank] == 8'h00; // RL5
      CMD_REF: legal = allIdle; // RL9
      CMD_MRS: legal = allIdle && s_reg.mrd == 8'h00; // RL2
      default: legal = 1'b1;
    endcase
    // Only another mode set may follow within the update delay
    if (reqCmd != CMD_MRS && s_reg.modw != 8'h00) begin
      legal = 1'b0; // RL3
    end
    if (s_reg.mprr != 8'h00) begin
      legal = 1'b0; // RL4
    end
  end

  assign reqReady = fallEn && legal;

  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.rdv = 1'b0;
    s_next.dqsSync = {s_reg.dqsSync[1], s_reg.dqsSync[0], link.dqs};
    s_next.dq1 = link.dq;
    s_next.dq2 = s_reg.dq1;
    // Link clock divider, ck high in the first half
    s_next.divCnt = (s_reg.divCnt == 8'(DIV - 1)) ? 8'h00 : s_reg.divCnt + 8'h01;
    s_next.ck = s_next.divCnt < 8'(HALF);
    if (fallEn) begin
      // Every constraint counter drains one per nCK
      s_next.cmd = CMD_NOP;
      if (s_reg.ccd != 8'h00) s_next.ccd = s_reg.ccd - 8'h01; // RL17
      if (s_reg.mrd != 8'h00) s_next.mrd = s_reg.mrd - 8'h01;
      if (s_reg.modw != 8'h00) s_next.modw = s_reg.modw - 8'h01;
      if (s_reg.mprr != 8'h00) s_next.mprr = s_reg.mprr - 8'h01;
      if (s_reg.wtr != 8'h00) s_next.wtr = s_reg.wtr - 8'h01;
      for (int b = 0; b < BANKS; b++) begin
        if (s_reg.rcd[b] != 8'h00) s_next.rcd[b] = s_reg.rcd[b] - 8'h01;
        if (s_reg.rc[b] != 8'h00) s_next.rc[b] = s_reg.rc[b] - 8'h01;
        if (s_reg.ras[b] != 8'h00) s_next.ras[b] = s_reg.ras[b] - 8'h01;
        if (s_reg.rtp[b] != 8'h00) s_next.rtp[b] = s_reg.rtp[b] - 8'h01;
        if (s_reg.rp[b] != 8'h00) s_next.rp[b] = s_reg.rp[b] - 8'h01;
        if (s_reg.dal[b] != 8'h00) s_next.dal[b] = s_reg.dal[b] - 8'h01;
      end
      if (s_reg.st != C_IDLE) s_next.slot = s_reg.slot + 8'h01;
      if (reqValid && legal) begin
        s_next.cmd = reqCmd;
        s_next.bank = reqBank;
        unique case (reqCmd)
          CMD_ACT: begin
            s_next.open[reqBank] = 1'b1;
            s_next.rcd[reqBank] = 8'(RCD_N - 1); // RL8
            s_next.rc[reqBank] = 8'(RC_N - 1); // RL9
            s_next.ras[reqBank] = 8'(RAS_N - 1); // RL10
          end
          CMD_RD: begin
            s_next.ccd = 8'(CCD_NCK - 1); // RL1
            s_next.rtp[reqBank] = 8'(RTP_N - 1); // RL5
            s_next.st = C_RD;
            s_next.slot = 8'h00;
            s_next.beat = 2'b00;
          end
          CMD_WR, CMD_WRA: begin
            s_next.ccd = 8'(CCD_NCK - 1); // RL1
            s_next.wtr = 8'(WEND_N + WTR_N - 1); // RL6
            s_next.st = C_WR;
            s_next.slot = 8'h00;
            s_next.wdata = reqWdata;
            if (reqCmd == CMD_WRA) begin
              // Bank busy until recovery and precharge finish
              s_next.open[reqBank] = 1'b0;
              s_next.dal[reqBank] = 8'(WEND_N + WR_NCK + RP_N - 1); // RL7
            end
          end
          CMD_PRE: begin
            s_next.open[reqBank] = 1'b0;
            s_next.rp[reqBank] = 8'(RP_N - 1);
          end
          CMD_REF: begin
            for (int b = 0; b < BANKS; b++) s_next.rc[b] = 8'(RC_N - 1); // RL9
          end
          CMD_MRS: begin
            s_next.mrd = 8'(MRD_NCK - 1); // RL2
            s_next.modw = 8'(MOD_N - 1); // RL3
          end
          CMD_MPRX: s_next.mprr = 8'(MPRR_NCK - 1); // RL4
          default: s_next.cmd = CMD_NOP;
        endcase
      end
      // Write strobe and data framed on ck falling
      if (s_reg.st == C_WR) begin
        if (s_next.slot == 8'(CWL - PRE_NCK)) begin
          s_next.oe_n = 1'b0;
          s_next.dqsOut = 1'b0; // RL11
        end else if (s_next.slot >= 8'(CWL) && s_next.slot < 8'(WEND_N)) begin
          s_next.dqsOut = ~(s_next.slot[0] ^ CWL[0]);
          s_next.dqOut = s_reg.wdata[8 * (s_next.slot - 8'(CWL)) +: 8];
        end else if (s_next.slot == 8'(WEND_N)) begin
          s_next.dqsOut = 1'b0; // RL12
        end else if (s_next.slot == 8'(WEND_N + POST_NCK)) begin
          s_next.oe_n = 1'b1;
          s_next.st = C_IDLE;
        end
      end
      // Read that never shows its beats gives up
      if (s_reg.st == C_RD && s_next.slot > 8'(RL + BEATS + 2)) begin
        s_next.st = C_IDLE;
      end
    end
    // Read beats caught on strobe edges, relies on RL15 and RL16 framing
    if (s_reg.st == C_RD && dqsEdge) begin
      s_next.rdat[8 * s_reg.beat +: 8] = s_reg.dq2;
      s_next.beat = s_reg.beat + 2'b01;
      if (s_reg.beat == 2'(BEATS - 1)) begin
        s_next.rdv = 1'b1;
        s_next.st = C_IDLE;
      end
    end
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= C_IDLE;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.ck = s_reg.ck;
  assign link.cmd = dct_cmd_t'(s_reg.cmd);
  assign link.bank = s_reg.bank;
  assign link.dqCtl = s_reg.dqOut;
  assign link.dqsCtl = s_reg.dqsOut;
  assign link.dqCtlOe_n = s_reg.oe_n;
  assign link.dqsCtlOe_n = s_reg.oe_n;
  assign rdValid = s_reg.rdv;
  assign rdData = s_reg.rdat;
endmodule // dct_ctrl_end

// file: tb/dct_props.sv
// Purpose: timing checks on the link between the two ends
// Assumes: one nCK is DIV clk_sys cycles; commands change where ck falls
// Notes: counters reset full and saturate, so the first command after reset always passes the spacing checks
`timescale 1ns/100ps
module dct_props import dct_pkg::*; #(
  parameter int DIV = 10,
  parameter int CWL = 5,
  parameter int RL = 6,
  parameter int MODN = 12,
  parameter int RCDN = 3,
  parameter int RASN = 5,
  parameter int RCN = 10,
  parameter int RPN = 3,
  parameter int WRN = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ck,
  input wire dct_cmd_t cmd,
  input wire logic [2:0] bank,
  input wire logic dqsCtl,
  input wire logic dqsCtlOe_n,
  input wire logic dqsMem,
  input wire logic dqsMemOe_n
);
  // Read strobe windows; the slack covers the memory's input syncs
  localparam int RD_ON_LO = (RL - 1) * DIV;
  localparam int RD_ON_HI = RL * DIV + 2;
  localparam int RD_OFF_LO = (RL + 4) * DIV;
  localparam int RD_OFF_HI = (RL + 5) * DIV + 2;
  logic ckReg; // Link clock one cycle back
  logic [15:0] sAny, sCol, sMrs, sRd, sWr, sWra, sAct; // Cycles since each kind
  logic [2:0] bRd, bWra, bAct; // Bank of the last read, auto-precharge write, activate
  wire issue = ckReg && !ck && (cmd != CMD_NOP); // Command starts its nCK
  wire isCol = cmd inside {CMD_RD, CMD_WR, CMD_WRA};

  // Restart on a hit, else count up and stick at the top
  function automatic logic [15:0] step(input logic hit, input logic [15:0] c);
    return hit ? 16'h0001 : ((c == 16'hFFFF) ? c : c + 16'h0001);
  endfunction

  // Spacing counters for any command, column commands, mode sets, reads, writes, auto writes and activates
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ckReg <= 1'b0;
      sAny <= 16'hFFFF;
      sCol <= 16'hFFFF;
      sMrs <= 16'hFFFF;
      sRd <= 16'hFFFF;
      sWr <= 16'hFFFF;
      sWra <= 16'hFFFF;
      sAct <= 16'hFFFF;
      bRd <= 3'h0;
      bWra <= 3'h0;
      bAct <= 3'h0;
    end else begin
      ckReg <= ck;
      sAny <= step(issue, sAny);
      sCol <= step(issue && isCol, sCol);
      sMrs <= step(issue && cmd == CMD_MRS, sMrs);
      sRd <= step(issue && cmd == CMD_RD, sRd);
      sWr <= step(issue && (cmd == CMD_WR || cmd == CMD_WRA), sWr);
      sWra <= step(issue && cmd == CMD_WRA, sWra);
      sAct <= step(issue && cmd == CMD_ACT, sAct);
      if (issue && cmd == CMD_RD) bRd <= bank;
      if (issue && cmd == CMD_WRA) bWra <= bank;
      if (issue && cmd == CMD_ACT) bAct <= bank;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_col_spacing: assert property (issue && isCol |-> sCol >= 4 * DIV)
    else $error("column commands too close");
  a_mrs_spacing: assert property (issue && cmd == CMD_MRS |-> sMrs >= 4 * DIV)
    else $error("mode sets too close");
  a_mod_delay: assert property (issue && !(cmd inside {CMD_MRS, CMD_MPRX}) |->
    sMrs >= MODN * DIV) else $error("command inside mode update delay");
  a_mpr_recover: assert property (issue |-> sAny >= DIV)
    else $error("commands closer than one clock");
  a_rtp_wait: assert property (issue && cmd == CMD_PRE && bank == bRd |->
    sRd >= 4 * DIV) else $error("precharge too soon after read");
  a_wtr_wait: assert property (issue && cmd == CMD_RD |-> sWr >= (CWL + 8) * DIV)
    else $error("read too soon after write data");
  a_dal_wait: assert property (issue && cmd == CMD_ACT && bank == bWra |->
    sWra >= (CWL + 4 + WRN + RPN) * DIV) else $error("bank busy after auto write");
  a_rcd_wait: assert property (issue && isCol && bank == bAct |-> sAct >= RCDN * DIV)
    else $error("column too soon after activate");
  a_rc_wait: assert property (issue && cmd == CMD_ACT && bank == bAct |->
    sAct >= RCN * DIV) else $error("activates too close");
  a_ras_wait: assert property (issue && cmd == CMD_PRE && bank == bAct |->
    sAct >= RASN * DIV) else $error("row closed too early");
  a_wr_preamble: assert property ($fell(dqsCtlOe_n) |-> sWr == (CWL - 1) * DIV &&
    !dqsCtl ##1 (!dqsCtl) [*8]) else $error("write preamble wrong");
  a_wr_postamble: assert property ($rose(dqsCtlOe_n) |-> sWr == (CWL + 5) * DIV &&
    !$past(dqsCtl) && !$past(dqsCtl, 8)) else $error("write postamble wrong");
  a_rd_preamble: assert property ($fell(dqsMemOe_n) |-> sRd inside {[RD_ON_LO:RD_ON_HI]} &&
    !dqsMem ##1 (!dqsMem) [*8]) else $error("read preamble wrong");
  a_rd_release: assert property ($rose(dqsMemOe_n) |-> sRd inside {[RD_OFF_LO:RD_OFF_HI]}
    && !$past(dqsMem)) else $error("read strobe release wrong");
endmodule // dct_props

// file: tb/tb_top.sv
// Purpose: drives both ends through a table of commands and checks spacing and data
// Assumes: a held request is taken at the first legal slot
// Notes: speed-bin times chosen as whole nCK so every gap is exact
`timescale 1ns/100ps
module tb_top;
  import dct_pkg::*;
  localparam int DIV = 10; // 80 ns link clock
  localparam int CWL = 5;
  localparam int RL = 6;
  localparam int TCK = DIV * SYS_PERIOD_PS; // Link period in ps
  localparam int RCDN = 3;
  localparam int RPN = 3;
  localparam int RASN = 5;
  localparam int RCN = 10;
  localparam int MODN = 12; // Floor wins over 15 ns at this clock
  localparam int WRN = 8;
  localparam logic [31:0] WA = 32'hA5C3_0F81; // Word for the plain write
  localparam logic [31:0] WB = 32'h1E2D_3C4B; // Word for the auto-precharge write
  logic clk_sys, rstn, reqValid, reqReady, rdValid, cmdSeen;
  dct_cmd_t reqCmd, cmdLast;
  logic [2:0] reqBank;
  logic [31:0] reqWdata, rdData;
  logic [31:0] rdQ[$]; // Completed read words
  int n_mismatch, compares, tLast, nExp, k;
  int cyc = 0; // Clock count, written only by the edge process
  int nSeen = 0; // Decoded commands, written only by the edge process

  dct_link_if dct_link_if_i ();
  dct_ctrl_end #(.DIV(DIV), .CWL(CWL), .RL(RL), .T_RCD_PS(RCDN * TCK), .T_RP_PS(RPN * TCK),
    .T_RAS_PS(RASN * TCK), .T_RC_PS(RCN * TCK), .T_MOD_PS(15000), .MOD_MIN_NCK(MODN),
    .WR_NCK(WRN)) dct_ctrl_end_i (.clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqBank(reqBank), .reqWdata(reqWdata), .reqReady(reqReady),
    .rdValid(rdValid), .rdData(rdData), .link(dct_link_if_i.ctl));
  dct_mem_end #(.RL(RL)) dct_mem_end_i (.clk_sys(clk_sys), .rstn(rstn),
    .link(dct_link_if_i.mem), .cmdSeen(cmdSeen), .cmdLast(cmdLast));
  dct_props #(.DIV(DIV), .CWL(CWL), .RL(RL), .MODN(MODN), .RCDN(RCDN), .RASN(RASN),
    .RCN(RCN), .RPN(RPN), .WRN(WRN)) dct_props_i (.clk_sys(clk_sys), .rstn(rstn),
    .ck(dct_link_if_i.ck), .cmd(dct_link_if_i.cmd), .bank(dct_link_if_i.bank),
    .dqsCtl(dct_link_if_i.dqsCtl), .dqsCtlOe_n(dct_link_if_i.dqsCtlOe_n),
    .dqsMem(dct_link_if_i.dqsMem), .dqsMemOe_n(dct_link_if_i.dqsMemOe_n));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Cycle count, read words and decoded commands; old values seen at each edge
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rdValid === 1'b1) rdQ.push_back(rdData);
    if (cmdSeen === 1'b1) nSeen <= nSeen + 1;
  end

  task automatic cmpi(input string what, input int exp, input int got);
    compares++;
    if (exp != got) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmpv(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold one request until taken, then check its distance from the last one
  task automatic run(input dct_cmd_t c, input logic [2:0] b, input logic [31:0] w,
      input int gapNck);
    int n;
    logic rdy;
    n = 0;
    reqValid <= 1'b1;
    reqCmd <= c;
    reqBank <= b;
    reqWdata <= w;
    do begin
      @(negedge clk_sys);
      rdy = reqReady;
      @(posedge clk_sys);
      n++;
    end while (rdy !== 1'b1 && n < 4000);
    reqValid <= 1'b0;
    cmpi("request taken", 1, int'(rdy === 1'b1));
    if (gapNck > 0) cmpi("issue gap", gapNck * DIV, cyc - tLast);
    tLast = cyc;
    nExp++;
    @(posedge clk_sys);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the hundred or so nCK of the sequence
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {n_mismatch, compares, tLast, nExp} = '0;
    rstn = 1'b0;
    reqValid = 1'b0;
    reqCmd = CMD_NOP;
    reqBank = 3'h0;
    reqWdata = 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    run(CMD_MRS, 3'h0, 32'h0000_0000, 0);
    run(CMD_MRS, 3'h0, 32'h0000_0000, MRD_NCK);
    run(CMD_ACT, 3'h1, 32'h0000_0000, MODN);
    run(CMD_WR, 3'h1, WA, RCDN);
    run(CMD_RD, 3'h1, 32'h0000_0000, CWL + 4 + 4);
    run(CMD_PRE, 3'h1, 32'h0000_0000, 4);
    run(CMD_ACT, 3'h1, 32'h0000_0000, RPN);
    run(CMD_PRE, 3'h1, 32'h0000_0000, RASN);
    run(CMD_ACT, 3'h1, 32'h0000_0000, RCN - RASN);
    run(CMD_WRA, 3'h1, WB, RCDN);
    run(CMD_ACT, 3'h1, 32'h0000_0000, CWL + 4 + WRN + RPN);
    run(CMD_RD, 3'h1, 32'h0000_0000, RCDN);
    run(CMD_MPRX, 3'h0, 32'h0000_0000, 1);
    run(CMD_MPRX, 3'h0, 32'h0000_0000, 1);
    run(CMD_PRE, 3'h1, 32'h0000_0000, 2);
    run(CMD_REF, 3'h0, 32'h0000_0000, RPN);
    k = 0;
    while ((rdQ.size() < 2 || cmdLast !== CMD_REF) && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    // Let the last decode reach the counters before looking
    repeat (2) @(posedge clk_sys);
    cmpi("reads returned", 2, rdQ.size());
    if (rdQ.size() >= 2) begin
      cmpv("first read word", WA, rdQ[0]);
      cmpv("second read word", WB, rdQ[1]);
    end
    cmpv("last command", {28'h000_0000, CMD_REF}, {28'h000_0000, cmdLast});
    cmpi("commands seen", nExp, nSeen);
    tally_and_finish();
  end
endmodule // tb_top
